// ### rtl/dplr_pkg.sv
// Purpose: Constants for the downstream port link and device status registers.
// Assumes: Configuration offsets are byte offsets into one port's space.
// Notes:   Dword addresses select a 32-bit word; byte enables pick lanes.
package dplr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] DEV_STATUS_OFS = 8'h9A;
    localparam logic [7:0] LINK_CAP_OFS   = 8'h9C;
    localparam logic [7:0] LINK_CTRL_OFS  = 8'hA0;
    localparam logic [7:0] LINK_STAT_OFS  = 8'hA2;

    // ------------------------------------------------------------------
    // Device status field positions
    // ------------------------------------------------------------------
    localparam int DS_NP_OUT_BIT = 5;
    localparam int DS_AUX_BIT    = 4;
    localparam int DS_UR_BIT     = 3;
    localparam int DS_FAT_BIT    = 2;
    localparam int DS_NFAT_BIT   = 1;
    localparam int DS_CORR_BIT   = 0;
    // The status word sits in the upper half of its dword.
    localparam int DS_WORD_LSB   = 16;

    // ------------------------------------------------------------------
    // Link capability fields and fixed codes
    // ------------------------------------------------------------------
    localparam int LC_PORT_LSB  = 24;
    localparam int LC_ACT_BIT   = 20;
    localparam int LC_SDN_BIT   = 19;
    localparam int LC_CLKREQ_BIT = 18;
    localparam int LC_L1_LSB    = 15;
    localparam int LC_L0S_LSB   = 12;
    localparam int LC_ASPM_LSB  = 10;
    localparam int LC_WIDTH_LSB = 4;
    localparam int LC_SPEED_LSB = 0;
    localparam logic [1:0] ASPM_SUPPORT_CODE = 2'h3;
    localparam logic [5:0] WIDTH_X1_CODE     = 6'h01;
    localparam logic [3:0] SPEED_2G5_CODE    = 4'h1;

    // ------------------------------------------------------------------
    // Link control fields
    // ------------------------------------------------------------------
    localparam int LK_CLKREQ_BIT   = 8;
    localparam int LK_XSYNC_BIT    = 7;
    localparam int LK_COMCLK_BIT   = 6;
    localparam int LK_RETRAIN_BIT  = 5;
    localparam int LK_OFF_BIT      = 4;
    localparam int LK_BOUNDARY_BIT = 3;
    localparam int LK_ASPM_LSB     = 0;
    localparam logic [15:0] LINK_CTRL_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Link status fields
    // ------------------------------------------------------------------
    localparam int ST_DLA_BIT    = 13;
    localparam int ST_REFCLK_BIT = 12;
    localparam int ST_TRN_BIT    = 11;
    localparam int ST_WIDTH_LSB  = 4;
    localparam int ST_SPEED_LSB  = 0;

    // Active state PM control encodings.
    typedef enum logic [1:0] {
        DPLR_ASPM_OFF  = 2'h0,
        DPLR_ASPM_L0S  = 2'h1,
        DPLR_ASPM_RSVD = 2'h2,
        DPLR_ASPM_BOTH = 2'h3
    } dplr_aspm_t;

endpackage

// ### rtl/dplr_regs.sv
// Purpose: Device status and link registers of one switch downstream port.
// Assumes: Configuration accesses are synchronous single-cycle strobes.
// Notes:   Read data is registered and valid one cycle after cfg_rd.
`timescale 1ns/1ns
`default_nettype none

module dplr_regs #(
    parameter int PORT_INDEX = 1,
    parameter int NP_CNT_W   = 5,
    parameter int RELOCK_ADD = 1
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    // Configuration access from the upstream host path.
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    input  wire logic [7:0]        cfg_addr,
    input  wire logic [3:0]        cfg_be,
    input  wire logic [31:0]       cfg_wdata,
    output logic [31:0]            cfg_rdata,
    output logic                   cfg_rvalid,
    // Status sources.
    input  wire logic              np_issue,
    input  wire logic              np_complete,
    input  wire logic              chip_aux_present,
    input  wire logic              ur_cpl_sent,
    input  wire logic              fatal_err_det,
    input  wire logic              nonfatal_err_det,
    input  wire logic              corr_err_det,
    input  wire logic              active_report_cfg,
    input  wire logic [2:0]        pm_l1_exit_cfg,
    input  wire logic [2:0]        pm_l0s_exit_cfg,
    input  wire logic [2:0]        endpoint_l1_base,
    input  wire logic              dl_state_active,
    input  wire logic              ltssm_cfg_or_rec,
    // Controls to the link.
    output logic                   nonposted_outstanding,
    output logic                   retrain_trigger,
    output logic                   link_off_bit,
    output logic                   clkreq_enable,
    output logic                   extended_sync,
    output logic                   common_refclk_config,
    output logic                   aspm_l0s_allow,
    output logic                   aspm_l1_allow,
    output logic [2:0]             endpoint_l1_accept,
    output logic                   training_active
);
    import dplr_pkg::*;

    // Parameter values that the fields cannot hold stop elaboration.
    if (PORT_INDEX < 1 || PORT_INDEX > 3) begin : g_bad_port
        $error("PORT_INDEX must be 1, 2 or 3");
    end
    if (NP_CNT_W < 1 || RELOCK_ADD < 0 || RELOCK_ADD > 7) begin : g_bad_cnt
        $error("NP_CNT_W or RELOCK_ADD out of range");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic sel_ds;
    logic sel_lcap;
    logic sel_lk;
    assign sel_ds   = cfg_addr[7:2] == DEV_STATUS_OFS[7:2];
    assign sel_lcap = cfg_addr[7:2] == LINK_CAP_OFS[7:2];
    assign sel_lk   = cfg_addr[7:2] == LINK_CTRL_OFS[7:2];

    // ------------------------------------------------------------------
    // Device status state
    // ------------------------------------------------------------------
    logic [NP_CNT_W-1:0] np_cnt_q;
    logic [NP_CNT_W-1:0] np_cnt_d;
    logic [3:0]          err_q;
    logic [3:0]          err_d;
    logic [3:0]          err_set;
    logic [3:0]          err_clr;

    assign err_set = {ur_cpl_sent, fatal_err_det, nonfatal_err_det,
                      corr_err_det};
    // The device status word sits in byte lanes 2 and 3 of its dword.
    assign err_clr = (cfg_wr && sel_ds && cfg_be[2]) ?
                     cfg_wdata[DS_WORD_LSB +: 4] : 4'h0;

    always_comb begin
        np_cnt_d = np_cnt_q;
        if (np_issue && !np_complete && !(&np_cnt_q)) begin
            np_cnt_d = np_cnt_q + 1'b1;
        end else if (np_complete && !np_issue && (|np_cnt_q)) begin
            np_cnt_d = np_cnt_q - 1'b1;
        end
        // Setting wins over a write-one clear in the same cycle.
        err_d = (err_q & ~err_clr) | err_set;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            np_cnt_q <= '0;
            err_q    <= 4'h0;
        end else begin
            np_cnt_q <= np_cnt_d;
            err_q    <= err_d;
        end
    end

    assign nonposted_outstanding = |np_cnt_q;

    // ------------------------------------------------------------------
    // Link control state
    // ------------------------------------------------------------------
    logic       ctl_clkreq_q;
    logic       ctl_clkreq_d;
    logic       ctl_xsync_q;
    logic       ctl_xsync_d;
    logic       ctl_comclk_q;
    logic       ctl_comclk_d;
    logic       ctl_off_q;
    logic       ctl_off_d;
    logic [1:0] ctl_aspm_q;
    logic [1:0] ctl_aspm_d;
    logic       retrain_q;
    logic       retrain_d;
    logic       lk_wr0;
    logic       lk_wr1;

    assign lk_wr0 = cfg_wr && sel_lk && cfg_be[0];
    assign lk_wr1 = cfg_wr && sel_lk && cfg_be[1];

    always_comb begin
        ctl_clkreq_d = ctl_clkreq_q;
        ctl_xsync_d  = ctl_xsync_q;
        ctl_comclk_d = ctl_comclk_q;
        ctl_off_d    = ctl_off_q;
        ctl_aspm_d   = ctl_aspm_q;
        retrain_d    = 1'b0;
        if (lk_wr1) begin
            ctl_clkreq_d = cfg_wdata[LK_CLKREQ_BIT];
        end
        if (lk_wr0) begin
            ctl_xsync_d  = cfg_wdata[LK_XSYNC_BIT];
            ctl_comclk_d = cfg_wdata[LK_COMCLK_BIT];
            ctl_off_d    = cfg_wdata[LK_OFF_BIT];
            ctl_aspm_d   = cfg_wdata[LK_ASPM_LSB +: 2];
            retrain_d    = cfg_wdata[LK_RETRAIN_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctl_clkreq_q <= LINK_CTRL_RST[LK_CLKREQ_BIT];
            ctl_xsync_q  <= LINK_CTRL_RST[LK_XSYNC_BIT];
            ctl_comclk_q <= LINK_CTRL_RST[LK_COMCLK_BIT];
            ctl_off_q    <= LINK_CTRL_RST[LK_OFF_BIT];
            ctl_aspm_q   <= LINK_CTRL_RST[LK_ASPM_LSB +: 2];
            retrain_q    <= 1'b0;
        end else begin
            ctl_clkreq_q <= ctl_clkreq_d;
            ctl_xsync_q  <= ctl_xsync_d;
            ctl_comclk_q <= ctl_comclk_d;
            ctl_off_q    <= ctl_off_d;
            ctl_aspm_q   <= ctl_aspm_d;
            retrain_q    <= retrain_d;
        end
    end

    assign retrain_trigger      = retrain_q;
    assign link_off_bit         = ctl_off_q;
    assign clkreq_enable        = ctl_clkreq_q;
    assign extended_sync        = ctl_xsync_q;
    assign common_refclk_config = ctl_comclk_q;

    // The reserved code 10 permits no entry at all.
    always_comb begin
        aspm_l0s_allow = 1'b0;
        aspm_l1_allow  = 1'b0;
        case (dplr_aspm_t'(ctl_aspm_q))
            DPLR_ASPM_L0S: begin
                aspm_l0s_allow = 1'b1;
            end
            DPLR_ASPM_BOTH: begin
                aspm_l0s_allow = 1'b1;
                aspm_l1_allow  = 1'b1;
            end
            default: begin
                aspm_l0s_allow = 1'b0;
            end
        endcase
    end

    // Clock request relock time widens the endpoint L1 acceptance,
    // saturating at the largest code.
    logic [3:0] l1_sum;
    assign l1_sum = {1'b0, endpoint_l1_base} + 4'(RELOCK_ADD);
    assign endpoint_l1_accept = !ctl_clkreq_q ? endpoint_l1_base :
                                (l1_sum[3] ? 3'h7 : l1_sum[2:0]);

    // ------------------------------------------------------------------
    // Link training status
    // ------------------------------------------------------------------
    logic in_cr_q;
    logic in_cr_d;
    logic trn_q;
    logic trn_d;

    always_comb begin
        in_cr_d = ltssm_cfg_or_rec;
        trn_d   = trn_q;
        if (in_cr_q && !ltssm_cfg_or_rec) begin
            trn_d = 1'b0;
        end
        if ((ltssm_cfg_or_rec && !in_cr_q) || retrain_q) begin
            trn_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            in_cr_q <= 1'b0;
            trn_q   <= 1'b0;
        end else begin
            in_cr_q <= in_cr_d;
            trn_q   <= trn_d;
        end
    end

    assign training_active = trn_q;

    // ------------------------------------------------------------------
    // Read images
    // ------------------------------------------------------------------
    logic [15:0] dev_status;
    logic [31:0] link_cap;
    logic [15:0] link_ctrl;
    logic [15:0] link_stat;

    always_comb begin
        dev_status              = 16'h0000;
        dev_status[DS_NP_OUT_BIT] = nonposted_outstanding;
        dev_status[DS_AUX_BIT]    = chip_aux_present;
        dev_status[DS_UR_BIT:DS_CORR_BIT] = err_q;

        link_cap = 32'h0000_0000;
        link_cap[LC_PORT_LSB +: 8]  = 8'(PORT_INDEX);
        link_cap[LC_ACT_BIT]        = active_report_cfg;
        link_cap[LC_SDN_BIT]        = active_report_cfg;
        link_cap[LC_CLKREQ_BIT]     = 1'b1;
        link_cap[LC_L1_LSB +: 3]    = pm_l1_exit_cfg;
        link_cap[LC_L0S_LSB +: 3]   = pm_l0s_exit_cfg;
        link_cap[LC_ASPM_LSB +: 2]  = ASPM_SUPPORT_CODE;
        link_cap[LC_WIDTH_LSB +: 6] = WIDTH_X1_CODE;
        link_cap[LC_SPEED_LSB +: 4] = SPEED_2G5_CODE;

        link_ctrl                   = 16'h0000;
        link_ctrl[LK_CLKREQ_BIT]    = ctl_clkreq_q;
        link_ctrl[LK_XSYNC_BIT]     = ctl_xsync_q;
        link_ctrl[LK_COMCLK_BIT]    = ctl_comclk_q;
        link_ctrl[LK_OFF_BIT]       = ctl_off_q;
        link_ctrl[LK_BOUNDARY_BIT]  = 1'b0;
        link_ctrl[LK_ASPM_LSB +: 2] = ctl_aspm_q;

        link_stat                    = 16'h0000;
        link_stat[ST_DLA_BIT]  = active_report_cfg && dl_state_active;
        link_stat[ST_REFCLK_BIT]     = 1'b1;
        link_stat[ST_TRN_BIT]        = trn_q;
        link_stat[ST_WIDTH_LSB +: 6] = WIDTH_X1_CODE;
        link_stat[ST_SPEED_LSB +: 4] = SPEED_2G5_CODE;
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        rvalid_q;

    // Device control in the low half of the status dword lives elsewhere
    // and reads zero here, as does any unmapped dword.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (cfg_rd) begin
            if (sel_ds) begin
                rdata_d = {dev_status, 16'h0000};
            end else if (sel_lcap) begin
                rdata_d = link_cap;
            end else if (sel_lk) begin
                rdata_d = {link_stat, link_ctrl};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= cfg_rd;
        end
    end

    assign cfg_rdata  = rdata_q;
    assign cfg_rvalid = rvalid_q;

endmodule

`default_nettype wire

// ### tb/dplr_host_model.sv
// Purpose: Host side issuing configuration reads and writes.
// Assumes: Strobes last one clock; inputs change at the falling edge.
// Notes:   Released address and data lines carry the inverse value.
`timescale 1ns/1ns
`default_nettype none
module dplr_host_model (
    input  wire logic        mclk,
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rvalid
);
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(negedge mclk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge mclk);
        cfg_wr = 1'b0;
        cfg_addr = ~a;
        cfg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic v);
        @(negedge mclk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge mclk);
        cfg_rd = 1'b0;
        cfg_addr = ~a;
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask
endmodule
`default_nettype wire

// ### tb/dplr_regs_assertions.sv
// Purpose: Port-level checks of the port status and link registers.
// Assumes: Reset is held for more than one clock.
// Notes:   Bound to every instance of dplr_regs.
`timescale 1ns/1ns
`default_nettype none
module dplr_regs_assertions #(
    parameter int PORT_INDEX = 1,
    parameter int RELOCK_ADD = 1
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [7:0]  cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        np_issue,
    input wire logic        np_complete,
    input wire logic        active_report_cfg,
    input wire logic        dl_state_active,
    input wire logic        ltssm_cfg_or_rec,
    input wire logic [2:0]  pm_l1_exit_cfg,
    input wire logic [2:0]  pm_l0s_exit_cfg,
    input wire logic [2:0]  endpoint_l1_base,
    input wire logic        nonposted_outstanding,
    input wire logic        retrain_trigger,
    input wire logic        link_off_bit,
    input wire logic        clkreq_enable,
    input wire logic        aspm_l0s_allow,
    input wire logic        aspm_l1_allow,
    input wire logic [2:0]  endpoint_l1_accept,
    input wire logic        training_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic [3:0] relock_sum;
    logic       ctl_wr;
    logic       cap_rd;
    logic       sts_rd;
    assign relock_sum = {1'b0, endpoint_l1_base} + 4'(RELOCK_ADD);
    assign ctl_wr = cfg_wr && cfg_addr[7:2] == 6'h28 && cfg_be[0];
    assign cap_rd = cfg_rd && cfg_addr[7:2] == 6'h27;
    assign sts_rd = cfg_rd && cfg_addr[7:2] == 6'h28;
    sequence retrain_req;
        ctl_wr && cfg_wdata[5];
    endsequence
    sequence retrain_run;
        retrain_trigger ##1 (!retrain_trigger && training_active);
    endsequence
    a_retrain_pulse: assert property (retrain_req |=> retrain_run)
        else $error("retrain write gave no single pulse");
    a_train_set: assert property ($rose(ltssm_cfg_or_rec) |=> training_active)
        else $error("training bit did not set");
    a_train_clear: assert property ($fell(ltssm_cfg_or_rec) &&
        !retrain_trigger |=> !training_active)
        else $error("training bit did not clear");
    a_nonposted_outstanding_set: assert property (np_issue && !np_complete |=>
        nonposted_outstanding)
        else $error("pending output not set");
    a_l1_accept: assert property (endpoint_l1_accept == (clkreq_enable ?
        (relock_sum > 4'h7 ? 3'h7 : relock_sum[2:0]) : endpoint_l1_base))
        else $error("endpoint L1 acceptance wrong");
    a_aspm_decode: assert property (ctl_wr |=>
        aspm_l1_allow == ($past(cfg_wdata[1:0]) == 2'h3) &&
        aspm_l0s_allow == $past(cfg_wdata[0]))
        else $error("power state permission wrong");
    a_link_off: assert property (ctl_wr |=> link_off_bit == $past(cfg_wdata[4]))
        else $error("link disable not taken");
    a_link_hold: assert property (!ctl_wr |=> $stable(link_off_bit))
        else $error("link disable changed without write");
    a_caps_read: assert property (cap_rd |=> cfg_rdata == {8'(PORT_INDEX),
        3'h0, {2{$past(active_report_cfg)}}, 1'b1, $past(pm_l1_exit_cfg),
        $past(pm_l0s_exit_cfg), 12'hC11})
        else $error("link capabilities wrong");
    a_status_read: assert property (sts_rd |=> cfg_rdata[31:26] == {2'h0,
        $past(active_report_cfg && dl_state_active), 1'b1,
        $past(training_active), 1'b0} && cfg_rdata[25:16] == 10'h011 &&
        cfg_rdata[15:9] == 7'h00 && cfg_rdata[5] == 1'b0 &&
        cfg_rdata[3:2] == 2'h0)
        else $error("link status or reserved bits wrong");
endmodule
bind dplr_regs dplr_regs_assertions #(
    .PORT_INDEX(PORT_INDEX), .RELOCK_ADD(RELOCK_ADD)
) dplr_regs_assertions_inst (
    .mclk, .srst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .np_issue, .np_complete, .active_report_cfg,
    .dl_state_active, .ltssm_cfg_or_rec, .pm_l1_exit_cfg, .pm_l0s_exit_cfg,
    .endpoint_l1_base, .nonposted_outstanding, .retrain_trigger,
    .link_off_bit, .clkreq_enable, .aspm_l0s_allow, .aspm_l1_allow,
    .endpoint_l1_accept, .training_active
);
`default_nettype wire

// ### tb/dplr_regs_bench.sv
// Purpose: Self-checking bench of the port status and link registers.
// Assumes: Inputs change at the falling edge of mclk.
// Notes:   Port index three exercises the top of its range.
`timescale 1ns/1ns
`default_nettype none
module dplr_regs_bench;
    localparam int PIDX = 3;
    localparam int RADD = 1;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [5:0]  evt = 6'h00;
    logic        chip_aux_present = 1'b1;
    logic        active_report_cfg = 1'b1;
    logic        dl_state_active = 1'b0;
    logic        ltssm_cfg_or_rec = 1'b0;
    logic [2:0]  pm_l1_exit_cfg = 3'h5;
    logic [2:0]  pm_l0s_exit_cfg = 3'h2;
    logic [2:0]  endpoint_l1_base = 3'h6;
    logic        cfg_wr, cfg_rd, cfg_rvalid;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic        nonposted_outstanding, retrain_trigger, link_off_bit;
    logic        clkreq_enable, extended_sync, common_refclk_config;
    logic        aspm_l0s_allow, aspm_l1_allow, training_active;
    logic [2:0]  endpoint_l1_accept;
    logic [9:0]  ctl;
    int          n_mismatch = 0;
    int          check_count = 0;
    assign ctl = {link_off_bit, clkreq_enable, extended_sync,
                  common_refclk_config, aspm_l1_allow, aspm_l0s_allow,
                  training_active, endpoint_l1_accept};
    always #2 mclk = ~mclk;
    dplr_regs #(.PORT_INDEX(PIDX), .NP_CNT_W(5), .RELOCK_ADD(RADD))
    dplr_regs_inst (
        .mclk, .srst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_rdata, .cfg_rvalid, .np_issue(evt[5]), .np_complete(evt[4]),
        .chip_aux_present, .ur_cpl_sent(evt[3]), .fatal_err_det(evt[2]),
        .nonfatal_err_det(evt[1]), .corr_err_det(evt[0]), .active_report_cfg,
        .pm_l1_exit_cfg, .pm_l0s_exit_cfg, .endpoint_l1_base,
        .dl_state_active, .ltssm_cfg_or_rec, .nonposted_outstanding,
        .retrain_trigger, .link_off_bit, .clkreq_enable, .extended_sync,
        .common_refclk_config, .aspm_l0s_allow, .aspm_l1_allow,
        .endpoint_l1_accept, .training_active
    );
    dplr_host_model host (
        .mclk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_rdata, .cfg_rvalid
    );
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        host.rd(a, d, v);
        chk_word("read valid", 32'h1, {31'h0, v});
        chk_word("read data", exp, d);
    endtask
    task automatic ev(input logic [5:0] m);
        @(negedge mclk);
        evt = m;
        @(negedge mclk);
        evt = 6'h00;
    endtask
    task automatic wait_neg(input int n);
        repeat (n) @(negedge mclk);
    endtask
    initial begin
        wait_neg(8);
        srst = 1'b0;
        rd_chk(8'h98, 32'h0010_0000);
        chip_aux_present = 1'b0;
        rd_chk(8'h98, 32'h0);
        rd_chk(8'hA4, 32'h0);
        for (int i = 0; i < 4; i++) begin
            {active_report_cfg, dl_state_active} = 2'(i);
            pm_l1_exit_cfg = 3'(7 - i);
            pm_l0s_exit_cfg = 3'(i);
            host.wr(8'h9C, 4'hF, 32'h0);
            rd_chk(8'h9C, {8'(PIDX), 3'h0, {2{i[1]}}, 1'b1, pm_l1_exit_cfg, pm_l0s_exit_cfg, 12'hC11});
            rd_chk(8'hA0, {2'h0, i == 3, 13'h1011, 16'h0});
        end
        ev(6'h0F);
        rd_chk(8'h98, 32'h000F_0000);
        host.wr(8'h98, 4'h3, 32'h000F_0000);
        rd_chk(8'h98, 32'h000F_0000);
        host.wr(8'h98, 4'h4, 32'h0005_0000);
        rd_chk(8'h98, 32'h000A_0000);
        fork
            host.wr(8'h98, 4'h4, 32'h000A_0000);
            ev(6'h02);
        join
        rd_chk(8'h98, 32'h0002_0000);
        ev(6'h20);
        ev(6'h20);
        ev(6'h10);
        ev(6'h30);
        rd_chk(8'h98, 32'h0022_0000);
        chk_word("pending", 32'h1, {31'h0, nonposted_outstanding});
        ev(6'h10);
        rd_chk(8'h98, 32'h0002_0000);
        chk_word("pending", 32'h0, {31'h0, nonposted_outstanding});
        for (int c = 0; c < 4; c++) begin
            host.wr(8'hA0, 4'h3, 32'hFFFF_FFFC | c);
            chk_word("retrain", 32'h1, {31'h0, retrain_trigger});
            rd_chk(8'hA0, {16'h3811, 16'h01D0 | 16'(c)});
            chk_word("controls", {22'h0, 4'hF, c == 3, c[0], 4'hF}, 32'(ctl));
        end
        endpoint_l1_base = 3'h2;
        host.wr(8'hA0, 4'h3, 32'h0);
        host.wr(8'hA0, 4'h2, 32'h0000_0100);
        chk_word("controls", 32'h10B, 32'(ctl));
        ltssm_cfg_or_rec = 1'b1;
        wait_neg(3);
        ltssm_cfg_or_rec = 1'b0;
        wait_neg(2);
        chk_word("controls", 32'h103, 32'(ctl));
        ltssm_cfg_or_rec = 1'b1;
        wait_neg(2);
        rd_chk(8'hA0, 32'h3811_0100);
        ltssm_cfg_or_rec = 1'b0;
        srst = 1'b1;
        wait_neg(8);
        srst = 1'b0;
        chk_word("controls", 32'h2, 32'(ctl));
        complete_run();
    end
    initial begin
        repeat (4000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
